// file: hdl/sgcr_pkg.sv
`default_nettype none
package sgcr_pkg;
  // Register offsets
  localparam logic [7:0] UPLINK_CTRL_OFS    = 8'h06;
  localparam logic [7:0] STORM_LOW_OFS      = 8'h07;
  localparam logic [7:0] FACTORY_A_OFS      = 8'h08;
  localparam logic [7:0] FACTORY_B_OFS      = 8'h09;
  localparam logic [7:0] FACTORY_C_OFS      = 8'h0a;
  localparam logic [7:0] PHY_MISC_OFS       = 8'h0b;
  // Field positions in the uplink control register, then the power-save bit in the PHY misc register
  localparam int         FLOW_CTRL_BIT      = 5;
  localparam int         LOW_SPEED_BIT      = 4;
  localparam int         NULL_VID_BIT       = 3;
  localparam int         STORM_HI_MSB       = 2;
  localparam int         PHY_SAVE_BIT       = 6;
  // Reset values and the PHY misc write mask
  localparam logic [5:0] UPLINK_CTRL_RST    = 6'h00;
  localparam logic [7:0] STORM_LOW_RST      = 8'h63;
  localparam logic [7:0] FACTORY_A_RST      = 8'h4e;
  localparam logic [7:0] FACTORY_B_RST      = 8'h24;
  localparam logic [7:0] FACTORY_C_RST      = 8'h24;
  localparam logic [6:0] PHY_MISC_RST       = 7'h08;
  localparam logic [7:0] PHY_MISC_WMASK     = 8'h7f;
  // Strap capture: two synchroniser stages, then load
  localparam logic [1:0] STRAP_LOAD_CNT     = 2'h2;
  localparam logic [1:0] STRAP_DONE_CNT     = 2'h3;
  // Storm measuring periods
  localparam int         CLK_KHZ            = 25000;
  localparam int         STORM_FAST_MS      = 67;
  localparam int         STORM_SLOW_MS      = 500;
  localparam int         STORM_FAST_CYC     = STORM_FAST_MS * CLK_KHZ;
  localparam int         STORM_SLOW_CYC     = STORM_SLOW_MS * CLK_KHZ;
  localparam int         PORT_COUNT         = 3;
  localparam int         LIMIT_W            = 11;
  localparam int         VID_W              = 12;
endpackage
`default_nettype wire

// file: hdl/sgcr_storm_meter.sv
`timescale 1ns/1ns
`default_nettype none
module sgcr_storm_meter
  import sgcr_pkg::*;
(
  // Clock and reset
  input  wire logic               core_clk_i,
  input  wire logic               reset_n_i,
  // Period and limit
  input  wire logic               period_tick_i,
  input  wire logic [LIMIT_W-1:0] limit_i,
  // Ingress frame events
  input  wire logic               frame_start_i,
  input  wire logic               frame_bcast_i,
  input  wire logic               block_i,
  // Verdict
  output logic                    drop_o
);
  logic [LIMIT_W-1:0] count_q;
  logic               in_bcast_q;

  // Verdict taken once per frame, so a frame is never cut mid-way
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      drop_o     <= 1'b0;
      in_bcast_q <= 1'b0;
    end
    else if (frame_start_i)
    begin
      drop_o     <= frame_bcast_i && (count_q >= limit_i);
      in_bcast_q <= frame_bcast_i && (count_q < limit_i);
    end
  end

  // Period boundary wins over a block in the same cycle
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      count_q <= '0;
    else if (period_tick_i)
      count_q <= '0;
    else if (block_i && in_bcast_q && (count_q != {LIMIT_W{1'b1}}))
      count_q <= count_q + 11'h001;
  end

  property p_tick_clears;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      period_tick_i |=> (count_q == '0);
  endproperty
  a_tick_clears: assert property (p_tick_clears) else $error("storm count not cleared at period");

  property p_drop_over_limit;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      frame_start_i && frame_bcast_i && (count_q >= limit_i) |=> drop_o;
  endproperty
  a_drop_over_limit: assert property (p_drop_over_limit) else $error("broadcast over limit not dropped");

  property p_no_drop_plain;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      frame_start_i && !frame_bcast_i |=> !drop_o;
  endproperty
  a_no_drop_plain: assert property (p_no_drop_plain) else $error("non-broadcast frame dropped");

  c_drop: cover property (@(posedge core_clk_i) disable iff (!reset_n_i) $rose(drop_o));
endmodule
`default_nettype wire

// file: hdl/sgcr_regs.sv
// Notes on behaviour
// - Flow-control bit enables uplink full-duplex pause; reset from pulled-down strap.
// - Speed bit set selects 10 Mbps uplink, clear 100 Mbps; reset from strap.
// - Null-VID bit set replaces a null VLAN ID with port default ID.
// - Storm limit is eleven bits: three high bits plus a full low byte.
// - Storm period is 500 ms at 10 Mbps, and 67 ms at 100.
// - After reset the storm limit is 0x063, about one percent of line rate.
// - PHY power-save bit puts the PHYs into power save; reset clear.
`timescale 1ns/1ns
`default_nettype none
module sgcr_regs
  import sgcr_pkg::*;
#(
  parameter int PERIOD_FAST_CYC = STORM_FAST_CYC,
  parameter int PERIOD_SLOW_CYC = STORM_SLOW_CYC
)
(
  // Clock and reset
  input  wire logic                  core_clk_i,
  input  wire logic                  reset_n_i,
  // Strap pins
  input  wire logic                  strap_pin_uplink_flow_ctrl_i,
  input  wire logic                  strap_pin_uplink_speed_i,
  // Register port
  input  wire logic [7:0]            reg_addr_i,
  input  wire logic                  reg_wr_en_i,
  input  wire logic [7:0]            reg_wdata_i,
  output logic [7:0]                 reg_rdata_o,
  // Controls to the switch core
  output logic                       uplink_flow_ctrl_en_o,
  output logic                       uplink_low_speed_select_o,
  output logic                       null_vid_replace_o,
  output logic [LIMIT_W-1:0]         storm_limit_o,
  output logic                       phy_power_save_o,
  output logic [7:0]                 factory_test_a_o,
  output logic [7:0]                 factory_test_b_o,
  output logic [7:0]                 factory_test_c_o,
  // VLAN tag path
  input  wire logic                  tag_valid_i,
  input  wire logic [VID_W-1:0]      tag_vid_i,
  input  wire logic [VID_W-1:0]      port_vid_i,
  output logic                       tag_valid_o,
  output logic [VID_W-1:0]           tag_vid_o,
  // Broadcast storm ingress events per port
  input  wire logic [PORT_COUNT-1:0] port_low_speed_i,
  input  wire logic [PORT_COUNT-1:0] frame_start_i,
  input  wire logic [PORT_COUNT-1:0] frame_bcast_i,
  input  wire logic [PORT_COUNT-1:0] block_i,
  output logic [PORT_COUNT-1:0]      storm_drop_o
);
  logic [1:0] strap_meta_q;
  logic [1:0] strap_sync_q;
  logic [1:0] strap_cnt_q;
  logic [5:0] uplink_ctrl_q;
  logic [7:0] storm_low_q;
  logic [7:0] fact_a_q;
  logic [7:0] fact_b_q;
  logic [7:0] fact_c_q;
  logic [6:0] phy_misc_q;
  logic       wr_ok;
  logic [31:0] fast_cnt_q;
  logic [31:0] slow_cnt_q;
  logic       fast_tick_q;
  logic       slow_tick_q;

  // Straps cross in from pins
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      strap_meta_q <= 2'h0;
      strap_sync_q <= 2'h0;
    end
    else
    begin
      strap_meta_q <= {strap_pin_uplink_flow_ctrl_i, strap_pin_uplink_speed_i};
      strap_sync_q <= strap_meta_q;
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      strap_cnt_q <= 2'h0;
    else if (strap_cnt_q != STRAP_DONE_CNT)
      strap_cnt_q <= strap_cnt_q + 2'h1;
  end

  // Writes held off until straps land, so software cannot be overwritten
  assign wr_ok = reg_wr_en_i && (strap_cnt_q == STRAP_DONE_CNT);

  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      uplink_ctrl_q <= UPLINK_CTRL_RST;
    else if (strap_cnt_q == STRAP_LOAD_CNT)
    begin
      uplink_ctrl_q[FLOW_CTRL_BIT] <= strap_sync_q[1];
      uplink_ctrl_q[LOW_SPEED_BIT] <= strap_sync_q[0];
    end
    else if (wr_ok && reg_addr_i == UPLINK_CTRL_OFS)
      uplink_ctrl_q <= reg_wdata_i[5:0];
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      storm_low_q <= STORM_LOW_RST;
    else if (wr_ok && reg_addr_i == STORM_LOW_OFS)
      storm_low_q <= reg_wdata_i;
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      fact_a_q <= FACTORY_A_RST;
      fact_b_q <= FACTORY_B_RST;
      fact_c_q <= FACTORY_C_RST;
    end
    else if (wr_ok)
    begin
      if (reg_addr_i == FACTORY_A_OFS)
        fact_a_q <= reg_wdata_i;
      if (reg_addr_i == FACTORY_B_OFS)
        fact_b_q <= reg_wdata_i;
      if (reg_addr_i == FACTORY_C_OFS)
        fact_c_q <= reg_wdata_i;
    end
  end

  // Top bit is read-only zero
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      phy_misc_q <= PHY_MISC_RST;
    else if (wr_ok && reg_addr_i == PHY_MISC_OFS)
      phy_misc_q <= reg_wdata_i[6:0] & PHY_MISC_WMASK[6:0];
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      reg_rdata_o <= 8'h00;
    else
    begin
      case (reg_addr_i)
        UPLINK_CTRL_OFS: reg_rdata_o <= {2'h0, uplink_ctrl_q};
        STORM_LOW_OFS:   reg_rdata_o <= storm_low_q;
        FACTORY_A_OFS:   reg_rdata_o <= fact_a_q;
        FACTORY_B_OFS:   reg_rdata_o <= fact_b_q;
        FACTORY_C_OFS:   reg_rdata_o <= fact_c_q;
        PHY_MISC_OFS:    reg_rdata_o <= {1'b0, phy_misc_q};
        default:         reg_rdata_o <= 8'h00;
      endcase
    end
  end

  assign uplink_flow_ctrl_en_o     = uplink_ctrl_q[FLOW_CTRL_BIT];
  assign uplink_low_speed_select_o = uplink_ctrl_q[LOW_SPEED_BIT];
  assign null_vid_replace_o        = uplink_ctrl_q[NULL_VID_BIT];
  assign storm_limit_o             = {uplink_ctrl_q[STORM_HI_MSB:0], storm_low_q};
  assign phy_power_save_o          = phy_misc_q[PHY_SAVE_BIT];
  assign factory_test_a_o          = fact_a_q;
  assign factory_test_b_o          = fact_b_q;
  assign factory_test_c_o          = fact_c_q;

  // One cycle of latency on the tag path
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      tag_valid_o <= 1'b0;
      tag_vid_o   <= '0;
    end
    else
    begin
      tag_valid_o <= tag_valid_i;
      if (null_vid_replace_o && tag_vid_i == '0)
        tag_vid_o <= port_vid_i;
      else
        tag_vid_o <= tag_vid_i;
    end
  end

  // Period dividers, shared by all ports of one speed
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      fast_cnt_q  <= 32'h0;
      slow_cnt_q  <= 32'h0;
      fast_tick_q <= 1'b0;
      slow_tick_q <= 1'b0;
    end
    else
    begin
      fast_tick_q <= (fast_cnt_q == 32'(PERIOD_FAST_CYC - 1));
      slow_tick_q <= (slow_cnt_q == 32'(PERIOD_SLOW_CYC - 1));
      fast_cnt_q  <= (fast_cnt_q == 32'(PERIOD_FAST_CYC - 1)) ? 32'h0 : fast_cnt_q + 32'h1;
      slow_cnt_q  <= (slow_cnt_q == 32'(PERIOD_SLOW_CYC - 1)) ? 32'h0 : slow_cnt_q + 32'h1;
    end
  end

  // Uplink is the last port and follows the speed bit
  for (genvar p = 0; p < PORT_COUNT; p++)
  begin : g_meter
    logic low_speed;
    assign low_speed = (p == PORT_COUNT - 1) ? uplink_low_speed_select_o : port_low_speed_i[p];
    sgcr_storm_meter u_meter (
      .core_clk_i    (core_clk_i),
      .reset_n_i     (reset_n_i),
      .period_tick_i (low_speed ? slow_tick_q : fast_tick_q),
      .limit_i       (storm_limit_o),
      .frame_start_i (frame_start_i[p]),
      .frame_bcast_i (frame_bcast_i[p]),
      .block_i       (block_i[p]),
      .drop_o        (storm_drop_o[p])
    );
  end

  property p_strap_load;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      strap_cnt_q == STRAP_LOAD_CNT |=> uplink_flow_ctrl_en_o == $past(strap_sync_q[1])
        && uplink_low_speed_select_o == $past(strap_sync_q[0]);
  endproperty
  a_strap_load: assert property (p_strap_load) else $error("strap not loaded");

  property p_speed_write;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      wr_ok && reg_addr_i == UPLINK_CTRL_OFS |=> uplink_low_speed_select_o == $past(reg_wdata_i[4]);
  endproperty
  a_speed_write: assert property (p_speed_write) else $error("speed bit write lost");

  property p_flow_write;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      wr_ok && reg_addr_i == UPLINK_CTRL_OFS |=> uplink_flow_ctrl_en_o == $past(reg_wdata_i[5]);
  endproperty
  a_flow_write: assert property (p_flow_write) else $error("flow bit write lost");

  property p_null_vid;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      null_vid_replace_o && tag_vid_i == '0 |=> tag_vid_o == $past(port_vid_i);
  endproperty
  a_null_vid: assert property (p_null_vid) else $error("null VID not replaced");

  property p_limit_hi;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      wr_ok && reg_addr_i == UPLINK_CTRL_OFS |=> storm_limit_o[10:8] == $past(reg_wdata_i[2:0]);
  endproperty
  a_limit_hi: assert property (p_limit_hi) else $error("storm high bits wrong");

  property p_limit_reset;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      strap_cnt_q == 2'h0 |-> storm_limit_o == 11'h063;
  endproperty
  a_limit_reset: assert property (p_limit_reset) else $error("storm limit reset wrong");

  property p_period_slow;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      slow_tick_q |-> (slow_cnt_q == 32'h0) ##1 !slow_tick_q;
  endproperty
  a_period_slow: assert property (p_period_slow) else $error("slow tick longer than a cycle");

  property p_phy_save;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      wr_ok && reg_addr_i == PHY_MISC_OFS |=> phy_power_save_o == $past(reg_wdata_i[6])
        && reg_rdata_o[7] == 1'b0;
  endproperty
  a_phy_save: assert property (p_phy_save) else $error("power save bit write lost");

  c_strap_hi: cover property (@(posedge core_clk_i) disable iff (!reset_n_i)
    strap_cnt_q == STRAP_LOAD_CNT && strap_sync_q[1]);
  c_null_vid: cover property (@(posedge core_clk_i) disable iff (!reset_n_i)
    null_vid_replace_o && tag_valid_i && tag_vid_i == '0);
  c_slow_tick: cover property (@(posedge core_clk_i) disable iff (!reset_n_i) slow_tick_q);
endmodule
`default_nettype wire

// file: tb/sgcr_regs_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module sgcr_regs_tb_top
  import sgcr_pkg::*;
;
  logic                  clk;
  logic                  rst_n;
  logic                  strap_fc;
  logic                  strap_sp;
  logic [7:0]            addr;
  logic                  wen;
  logic [7:0]            wdata;
  logic [7:0]            rdata;
  logic                  flow;
  logic                  lows;
  logic                  nullv;
  logic [LIMIT_W-1:0]    limit;
  logic                  psave;
  logic [7:0]            fta;
  logic [7:0]            ftb;
  logic [7:0]            ftc;
  logic                  tvi;
  logic [VID_W-1:0]      tvid;
  logic [VID_W-1:0]      pvid;
  logic                  tvo;
  logic [VID_W-1:0]      tvido;
  logic [PORT_COUNT-1:0] pls;
  logic [PORT_COUNT-1:0] fs;
  logic [PORT_COUNT-1:0] fb;
  logic [PORT_COUNT-1:0] blk;
  logic [PORT_COUNT-1:0] drop;
  int                    failures;
  int                    n_compared;
  int                    cyc = 0;

  // Short periods keep the run brief
  sgcr_regs #(.PERIOD_FAST_CYC(40), .PERIOD_SLOW_CYC(100)) u_sgcr_regs (
    .core_clk_i(clk), .reset_n_i(rst_n),
    .strap_pin_uplink_flow_ctrl_i(strap_fc), .strap_pin_uplink_speed_i(strap_sp),
    .reg_addr_i(addr), .reg_wr_en_i(wen), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .uplink_flow_ctrl_en_o(flow), .uplink_low_speed_select_o(lows), .null_vid_replace_o(nullv),
    .storm_limit_o(limit), .phy_power_save_o(psave),
    .factory_test_a_o(fta), .factory_test_b_o(ftb), .factory_test_c_o(ftc),
    .tag_valid_i(tvi), .tag_vid_i(tvid), .port_vid_i(pvid), .tag_valid_o(tvo), .tag_vid_o(tvido),
    .port_low_speed_i(pls), .frame_start_i(fs), .frame_bcast_i(fb), .block_i(blk), .storm_drop_o(drop)
  );

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic close_out;
    $display("compared=%0d failures=%0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Ceiling well above the expected few hundred cycles
  always @(posedge clk)
  begin
    if (rst_n)
      cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      failures++;
      close_out();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wen   <= 1'b1;
    @(posedge clk);
    wen   <= 1'b0;
    #1;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    @(posedge clk);
    #1;
    chk(rdata, exp);
  endtask

  task automatic tg(input logic [11:0] v, input logic [11:0] p, input logic [12:0] exp);
    @(posedge clk);
    tvi  <= 1'b1;
    tvid <= v;
    pvid <= p;
    @(posedge clk);
    #1;
    chk({tvo, tvido}, exp);
  endtask

  // Frame start and block pulses, one cycle each; broadcast qualifier left held
  task automatic ev(input logic [2:0] s, input logic [2:0] b, input logic [2:0] k);
    @(posedge clk);
    fs  <= s;
    fb  <= b;
    blk <= k;
    @(posedge clk);
    fs  <= 3'h0;
    blk <= 3'h0;
  endtask

  task automatic wait_mod(input int m);
    while (cyc % 200 != m)
      @(posedge clk);
  endtask

  initial
  begin
    failures = 0; n_compared = 0;
    rst_n = 1'b0; strap_fc = 1'b1; strap_sp = 1'b1;
    addr = 8'h00; wen = 1'b0; wdata = 8'h00;
    tvi = 1'b0; tvid = 12'h000; pvid = 12'h000;
    pls = 3'h0; fs = 3'h0; fb = 3'h0; blk = 3'h0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    // Too early: straps not yet loaded, write must be dropped
    wr(STORM_LOW_OFS, 8'h11);
    rdchk(STORM_LOW_OFS, 8'h63);
    rdchk(UPLINK_CTRL_OFS, 8'h30);
    chk(flow, 1'b1);
    chk(lows, 1'b1);
    chk(limit, 11'h063);
    chk(psave, 1'b0);
    rdchk(FACTORY_A_OFS, 8'h4e);
    rdchk(FACTORY_B_OFS, 8'h24);
    rdchk(FACTORY_C_OFS, 8'h24);
    rdchk(PHY_MISC_OFS, 8'h08);
    chk({fta, ftb}, 16'h4e24);
    chk(ftc, 8'h24);
    for (int i = 0; i < 3; i++)
    begin
      wr(FACTORY_A_OFS + 8'(i), 8'h5a ^ 8'(i));
      rdchk(FACTORY_A_OFS + 8'(i), 8'h5a ^ 8'(i));
    end
    chk({fta, ftb}, 16'h5a5b);
    chk(ftc, 8'h58);
    wr(UPLINK_CTRL_OFS, 8'hcd);
    chk({flow, lows, nullv}, 3'b001);
    rdchk(UPLINK_CTRL_OFS, 8'h0d);
    wr(STORM_LOW_OFS, 8'ha5);
    chk(limit, 11'h5a5);
    wr(PHY_MISC_OFS, 8'hff);
    chk(psave, 1'b1);
    rdchk(PHY_MISC_OFS, 8'h7f);
    wr(PHY_MISC_OFS, 8'h08);
    chk(psave, 1'b0);
    wr(8'h20, 8'hff);
    rdchk(8'h20, 8'h00);
    tg(12'h000, 12'h005, 13'h1005);
    tg(12'h123, 12'h005, 13'h1123);
    wr(UPLINK_CTRL_OFS, 8'h05);
    tg(12'h000, 12'h005, 13'h1000);
    tvi <= 1'b0;
    wr(UPLINK_CTRL_OFS, 8'h10);
    chk(lows, 1'b1);
    wr(STORM_LOW_OFS, 8'h01);
    chk(limit, 11'h001);
    // Port 0 at 100 Mbps, port 1 at 10 Mbps, uplink slow by its speed bit; window avoids period ticks
    pls <= 3'b010;
    wait_mod(45);
    ev(3'b111, 3'b111, 3'h0);
    @(posedge clk);
    #1;
    chk(drop, 3'b000);
    ev(3'h0, 3'h0, 3'b111);
    ev(3'b111, 3'b111, 3'h0);
    @(posedge clk);
    #1;
    chk(drop, 3'b111);
    // Past a fast tick but before the slow one
    wait_mod(85);
    ev(3'b111, 3'b111, 3'h0);
    @(posedge clk);
    #1;
    chk(drop, 3'b110);
    ev(3'b010, 3'b000, 3'h0);
    @(posedge clk);
    #1;
    chk(drop, 3'b100);
    // Second reset with the speed strap low: loaded bits must follow the pins
    @(posedge clk);
    rst_n    <= 1'b0;
    strap_sp <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    chk(drop, 3'h0);
    rdchk(STORM_LOW_OFS, 8'h63);
    rdchk(UPLINK_CTRL_OFS, 8'h20);
    chk({flow, lows}, 2'b10);
    chk(limit, 11'h063);
    chk(psave, 1'b0);
    close_out();
  end
endmodule
`default_nettype wire
